// File: logic/tp_count_source.sv
// tp_count_source: picks instruction clock or an edge of the external count input
// assumes the external input is already synchronous to aclk
`timescale 1ns/10ps
module tp_count_source import tp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic count_source_select,
	input wire logic external_edge_select,
	input wire logic external_count_input,
	output logic src_tick
);
	typedef struct packed {
		logic prev;
		logic seen;
	} tp_src_s;
	tp_src_s s_ff;
	tp_src_s nxt_s;
	logic rise;
	logic fall;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.prev = external_count_input;
		nxt_s.seen = 1'b1;
		rise = s_ff.seen && !s_ff.prev && external_count_input;
		fall = s_ff.seen && s_ff.prev && !external_count_input;
		// instruction clock or chosen edge
		if (!count_source_select) begin
			src_tick = clk_en;
		end else begin
			src_tick = clk_en && (external_edge_select ? fall : rise);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	AST_EXT_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && count_source_select && src_tick) |-> (s_ff.prev == external_edge_select))
		else $error("external tick on wrong edge");
endmodule : tp_count_source

// File: logic/tp_pkg.sv
// tp_pkg: shared constants for the timer and pwm block
// assumes a 100 MHz aclk and an AXI4-Lite register bus with 8-bit byte addresses
package tp_pkg;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 5;
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_COUNT = 5'h09;
	localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 5'h0A;
	localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_DUTY_LOW = 5'h0C;
	localparam logic [IDX_W-1:0] IDX_PRESCALE_VAL = 5'h0D;
	localparam logic [IDX_W-1:0] IDX_HIGH_BITS = 5'h14;
	// control one fields
	localparam int C1_EN = 0;
	localparam int C1_RL = 1;
	localparam int C1_OS = 2;
	localparam int C1_OAL = 6;
	localparam int C1_OEN = 7;
	// control two fields
	localparam int C2_SEL_LO = 0;
	localparam int C2_PSDIS_N = 3;
	localparam int C2_EDGE = 4;
	localparam int C2_CS = 5;
	// shared high bits fields
	localparam int HB_DUTY_LO = 2;
	localparam int HB_RELOAD_LO = 6;
	// reset values
	localparam logic [7:0] RST_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO = 8'h3F;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_COUNT = 10'h000;
	localparam logic [7:0] RST_PRESCALE = 8'hFF;
	// counter limits
	localparam logic [9:0] COUNT_FULL = 10'h3FF;
	localparam logic [9:0] COUNT_ZERO = 10'h000;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tp_pkg

// File: logic/tp_prescaler.sv
// tp_prescaler: power-of-two divider between count source and timer decrement
// assumes in_tick already carries the clock enable
`timescale 1ns/10ps
module tp_prescaler import tp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic run,
	input wire logic in_tick,
	input wire logic prescaler_disable_n,
	input wire logic [2:0] prescaler_ratio_select,
	output logic out_tick,
	output logic [7:0] prescale_value
);
	typedef struct packed {
		logic [7:0] cnt;
	} tp_ps_s;
	tp_ps_s s_ff;
	tp_ps_s nxt_s;
	logic [7:0] mask;

	always_comb begin
		nxt_s = s_ff;
		// code n divides by 2 to the n+1
		mask = 8'(({1'b0, 8'hFF} << ({1'b0, prescaler_ratio_select} + 4'h1)) >> 0);
		mask = ~mask;
		if (prescaler_disable_n) begin
			out_tick = in_tick && run;
		end else begin
			if (in_tick && run) begin
				nxt_s.cnt = s_ff.cnt + 8'h01;
			end
			out_tick = in_tick && run && ((nxt_s.cnt & mask) == 8'h00);
		end
		prescale_value = s_ff.cnt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff.cnt <= RST_PRESCALE;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	AST_DIVIDE: assert property (@(posedge aclk) disable iff (!aresetn)
		(out_tick && !prescaler_disable_n) |-> ((s_ff.cnt + 8'h01) & mask) == 8'h00)
		else $error("prescaler tick off its ratio");
	AST_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && prescaler_disable_n) |=> $stable(s_ff.cnt))
		else $error("bypassed prescaler moved");
endmodule : tp_prescaler

// File: logic/tp_timer_pwm.sv
// tp_timer_pwm: 10-bit down-counting timer with reload, one-shot and pwm pin
// assumes an AXI4-Lite master on aclk; external count input synchronous to aclk
`timescale 1ns/10ps
module tp_timer_pwm import tp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_input,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic pwm_port_pin_out,
	output logic pwm_port_pin_oe
);
	typedef struct packed {
		logic [9:0] count;
		logic [7:0] reload;
		logic [7:0] high_bits;
		logic [7:0] duty_low;
		logic [7:0] ctrl_one;
		logic [7:0] ctrl_two;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [7:0] wbyte;
		logic wlane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic pin_out;
		logic pin_oe;
	} tp_top_s;

	tp_top_s s_ff;
	tp_top_s nxt_s;
	logic src_tick;
	logic dec_tick;
	logic [7:0] prescale_value;
	logic wr_fire;
	logic wr_count;
	logic [5:0] wr_dec;
	logic [5:0] rd_dec;
	logic [9:0] duty_full;
	logic [7:0] rd_byte;

	// valid flag and index of a byte address
	function automatic logic [5:0] tp_decode(input logic [ADDR_W-1:0] addr);
		logic [IDX_W-1:0] idx;
		logic hit;
		idx = addr[IDX_W+1:2];
		hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1] == 1'b0) && ((idx == IDX_COUNT) ||
			(idx == IDX_CTRL_ONE) || (idx == IDX_CTRL_TWO) || (idx == IDX_DUTY_LOW) ||
			(idx == IDX_PRESCALE_VAL) || (idx == IDX_HIGH_BITS));
		return {hit, idx};
	endfunction : tp_decode

	// ten-bit counter value from the two high reload bits and a low byte
	function automatic logic [9:0] tp_join_reload(input logic [7:0] hi_bits, input logic [7:0] lo_byte);
		return {hi_bits[HB_RELOAD_LO+:2], lo_byte};
	endfunction : tp_join_reload

	tp_count_source u_source (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.count_source_select(s_ff.ctrl_two[C2_CS]),
		.external_edge_select(s_ff.ctrl_two[C2_EDGE]),
		.external_count_input(external_count_input),
		.src_tick(src_tick)
	);

	tp_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.run(s_ff.ctrl_one[C1_EN]),
		.in_tick(src_tick),
		.prescaler_disable_n(s_ff.ctrl_two[C2_PSDIS_N]),
		.prescaler_ratio_select(s_ff.ctrl_two[C2_SEL_LO+:3]),
		.out_tick(dec_tick),
		.prescale_value(prescale_value)
	);

	always_comb begin
		nxt_s = s_ff;
		duty_full = {s_ff.high_bits[HB_DUTY_LO+:2], s_ff.duty_low};
		// timer step
		if (dec_tick && s_ff.ctrl_one[C1_EN]) begin
			if (s_ff.count != COUNT_ZERO) begin
				nxt_s.count = s_ff.count - 10'h001;
			end else if (s_ff.ctrl_one[C1_OS]) begin
				nxt_s.count = COUNT_ZERO;
			end else if (s_ff.ctrl_one[C1_RL]) begin
				nxt_s.count = tp_join_reload(s_ff.high_bits, s_ff.reload);
			end else begin
				nxt_s.count = COUNT_FULL;
			end
		end
		// write channel capture
		if (s_axi_awvalid && s_ff.awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wbyte = s_axi_wdata[7:0];
			nxt_s.wlane0 = s_axi_wstrb[0];
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		wr_fire = nxt_s.aw_got && nxt_s.w_got && !s_ff.bvalid;
		wr_dec = tp_decode(nxt_s.aw_addr);
		wr_count = 1'b0;
		if (wr_fire) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = wr_dec[5] ? RESP_OKAY : RESP_SLVERR;
			if (wr_dec[5] && nxt_s.wlane0) begin
				unique case (wr_dec[4:0])
					IDX_COUNT: begin
						wr_count = 1'b1;
						nxt_s.reload = nxt_s.wbyte;
						nxt_s.count = tp_join_reload(s_ff.high_bits, nxt_s.wbyte);
					end
					IDX_CTRL_ONE: nxt_s.ctrl_one = nxt_s.wbyte & 8'hC7;
					IDX_CTRL_TWO: nxt_s.ctrl_two = nxt_s.wbyte & 8'h3F;
					IDX_DUTY_LOW: nxt_s.duty_low = nxt_s.wbyte;
					IDX_HIGH_BITS: nxt_s.high_bits = nxt_s.wbyte & 8'hCC;
					default: ;
				endcase
			end
		end
		nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
		// read channel
		rd_dec = tp_decode(s_axi_araddr);
		unique case (rd_dec[4:0])
			IDX_COUNT: rd_byte = s_ff.count[7:0];
			IDX_CTRL_ONE: rd_byte = s_ff.ctrl_one;
			IDX_CTRL_TWO: rd_byte = s_ff.ctrl_two;
			IDX_DUTY_LOW: rd_byte = s_ff.duty_low;
			IDX_PRESCALE_VAL: rd_byte = prescale_value;
			IDX_HIGH_BITS: rd_byte = s_ff.high_bits;
			default: rd_byte = 8'h00;
		endcase
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_ff.arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = {24'h000000, rd_dec[5] ? rd_byte : 8'h00};
			nxt_s.rresp = rd_dec[5] ? RESP_OKAY : RESP_SLVERR;
		end
		nxt_s.arready = !nxt_s.rvalid;
		// pin drive
		if (s_ff.ctrl_one[C1_OEN]) begin
			nxt_s.pin_out = (s_ff.count <= duty_full) ^ s_ff.ctrl_one[C1_OAL];
			nxt_s.pin_oe = 1'b1;
		end else begin
			nxt_s.pin_out = gpio_out;
			nxt_s.pin_oe = gpio_oe;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
			s_ff.count <= RST_COUNT;
			s_ff.reload <= RST_BYTE;
			s_ff.high_bits <= RST_BYTE;
			s_ff.duty_low <= RST_BYTE;
			s_ff.ctrl_one <= RST_CTRL_ONE;
			s_ff.ctrl_two <= RST_CTRL_TWO;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign pwm_port_pin_out = s_ff.pin_out;
	assign pwm_port_pin_oe = s_ff.pin_oe;

	// checks
	sequence seq_underflow;
		clk_en && dec_tick && s_ff.ctrl_one[C1_EN] && (s_ff.count == COUNT_ZERO) && !wr_count;
	endsequence
	sequence seq_count_read;
		clk_en && s_axi_arvalid && s_ff.arready && tp_decode(s_axi_araddr) == {1'b1, IDX_COUNT};
	endsequence

	AST_COUNT_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_count_read |=> s_ff.rvalid && (s_ff.rdata == {24'h000000, $past(s_ff.count[7:0])}))
		else $error("count read returned wrong value");
	AST_COUNT_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_count) |=> (s_ff.count[7:0] == s_ff.reload) &&
		(s_ff.count[9:8] == s_ff.high_bits[HB_RELOAD_LO+:2]))
		else $error("count write did not load counter");
	AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && !s_ff.ctrl_one[C1_EN] && !wr_count) |=> $stable(s_ff.count))
		else $error("counter moved while disabled");
	AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_underflow and (!s_ff.ctrl_one[C1_OS] && !s_ff.ctrl_one[C1_RL])) |=> s_ff.count == COUNT_FULL)
		else $error("non-stop underflow did not wrap to full scale");
	AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_underflow and (!s_ff.ctrl_one[C1_OS] && s_ff.ctrl_one[C1_RL])) |=>
		s_ff.count == {$past(s_ff.high_bits[7:6]), $past(s_ff.reload)})
		else $error("auto-reload underflow loaded wrong value");
	AST_ONE_SHOT: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_underflow and s_ff.ctrl_one[C1_OS]) |=> s_ff.count == COUNT_ZERO)
		else $error("single-shot counter left zero");
	AST_PWM_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && s_ff.ctrl_one[C1_OEN]) |=> pwm_port_pin_oe &&
		(pwm_port_pin_out == (($past(s_ff.count) <= $past(duty_full)) ^ $past(s_ff.ctrl_one[C1_OAL]))))
		else $error("pwm pin level wrong");
	AST_GPIO_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && !s_ff.ctrl_one[C1_OEN]) |=> (pwm_port_pin_out == $past(gpio_out)) &&
		(pwm_port_pin_oe == $past(gpio_oe)))
		else $error("gpio not passed to pin");
	AST_INSTR_CLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && s_ff.ctrl_one[C1_EN] && !s_ff.ctrl_two[C2_CS] && s_ff.ctrl_two[C2_PSDIS_N] &&
		(s_ff.count != COUNT_ZERO) && !wr_count) |=> s_ff.count == $past(s_ff.count) - 10'h001)
		else $error("instruction clock did not step counter");
	AST_SRC_INSTR: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && !s_ff.ctrl_two[C2_CS]) |-> src_tick)
		else $error("instruction clock gave no source tick");
	AST_BYPASS_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && s_ff.ctrl_one[C1_EN] && s_ff.ctrl_two[C2_PSDIS_N]) |-> (dec_tick == src_tick))
		else $error("bypassed prescaler did not pass every tick");

	// bus checks
	sequence seq_write_both;
		clk_en && s_axi_awvalid && s_ff.awready && s_axi_wvalid && s_ff.wready;
	endsequence
	sequence seq_read_taken;
		clk_en && s_axi_arvalid && s_ff.arready;
	endsequence

	AST_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
		!clk_en |=> $stable(s_ff))
		else $error("state moved while clock enable low");
	AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_write_both |=> s_ff.bvalid && !s_ff.awready && !s_ff.wready)
		else $error("write not answered");
	AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_read_taken |=> s_ff.rvalid && !s_ff.arready)
		else $error("read not answered");
	AST_WRITE_REFUSED: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ff.bvalid |-> !s_ff.awready && !s_ff.wready)
		else $error("write channel open during answer");
	AST_READ_REFUSED: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ff.rvalid |-> !s_ff.arready)
		else $error("read channel open during answer");
	AST_UNMAPPED_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_read_taken and !rd_dec[5]) |=> (s_ff.rresp == RESP_SLVERR) && (s_ff.rdata == 32'h00000000))
		else $error("unmapped read not refused");
	AST_UNMAPPED_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_fire && !wr_dec[5]) |=> (s_ff.bresp == RESP_SLVERR) && $stable(s_ff.ctrl_one) &&
		$stable(s_ff.ctrl_two))
		else $error("unmapped write not refused");
	AST_SPARE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		((s_ff.ctrl_one & 8'h38) == 8'h00) && (s_ff.ctrl_two[7:6] == 2'h0) && ((s_ff.high_bits & 8'h33) == 8'h00))
		else $error("unused control bits set");
endmodule : tp_timer_pwm

// File: tb/test_timer2_pwm_prescaler.sv
// test_timer2_pwm_prescaler: self-checking bench for the timer and pwm block
// assumes tp_pkg and tp_timer_pwm compiled first; bench drives every port itself
`timescale 1ns/10ps
module test_timer2_pwm_prescaler import tp_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic ext = 1'h0;
	logic gpio_out = 1'h0;
	logic gpio_oe = 1'h0;
	logic clk_en = 1'h1;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, pin, oe;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, rv;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// addr, write data, expected read, expected response
	logic [25:0] rows [9] = '{{8'h28, 8'hFF, 8'hC7, 2'h0}, {8'h28, 8'h00, 8'h00, 2'h0},
		{8'h2C, 8'hFF, 8'h3F, 2'h0}, {8'h2C, 8'h00, 8'h00, 2'h0}, {8'h30, 8'hA5, 8'hA5, 2'h0},
		{8'h50, 8'hFF, 8'hCC, 2'h0}, {8'h24, 8'h5A, 8'h5A, 2'h0}, {8'h80, 8'hFF, 8'h00, 2'h2},
		{8'h25, 8'hFF, 8'h00, 2'h2}};
	// addr, reset value
	logic [15:0] rst_rows [6] = '{16'h2400, 16'h2800, 16'h2C3F, 16'h3000, 16'h34FF, 16'h5000};

	tp_timer_pwm i_tp_timer_pwm (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_count_input(ext), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.pwm_port_pin_out(pin), .pwm_port_pin_oe(oe));

	initial begin
		forever #5 aclk = ~aclk;
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		bh = 1'h0;
		while (!bh) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid === 1'h1;
			r = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
		end
		bready <= 1'h0;
	endtask : wr

	task rd(input logic [7:0] a);
		logic ah, dh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		dh = 1'h0;
		while (!dh) begin
			@(negedge aclk);
			ah = arvalid && arready;
			dh = rvalid === 1'h1;
			rv = rdata;
			r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'h0;
		end
		rready <= 1'h0;
	endtask : rd

	task pulse(input int n);
		repeat (n) begin
			@(posedge aclk) ext <= 1'h1;
			@(posedge aclk) ext <= 1'h0;
		end
		repeat (3) @(posedge aclk);
	endtask : pulse

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			conclude;
		end
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			wr(rows[i][25:18], rows[i][17:10]);
			chk("bresp", r, rows[i][1:0]);
			rd(rows[i][25:18]);
			chk("rdata", rv, rows[i][9:2]);
			chk("rresp", r, rows[i][1:0]);
		end
		$display("table done");
		@(posedge aclk) aresetn <= 1'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		chk("pin oe reset", oe, 1'h0);
		for (int i = 0; i < 6; i++) begin
			rd(rst_rows[i][15:8]);
			chk("reset value", rv, rst_rows[i][7:0]);
		end
		$display("reset done");
		wr(8'h2C, 8'h38);
		wr(8'h50, 8'h40);
		wr(8'h30, 8'hFF);
		wr(8'h24, 8'h01);
		wr(8'h28, 8'h81);
		repeat (3) @(posedge aclk);
		chk("pin high reload", pin, 1'h0);
		chk("pin oe", oe, 1'h1);
		pulse(2);
		chk("pin duty", pin, 1'h1);
		rd(8'h24);
		chk("count", rv, 32'hFF);
		wr(8'h28, 8'h80);
		pulse(3);
		rd(8'h24);
		chk("count halted", rv, 32'hFF);
		wr(8'h28, 8'hC1);
		repeat (3) @(posedge aclk);
		chk("pin active low", pin, 1'h0);
		pulse(256);
		rd(8'h24);
		chk("wrap full", rv, 32'hFF);
		wr(8'h50, 8'h00);
		wr(8'h28, 8'h83);
		wr(8'h24, 8'h02);
		pulse(3);
		rd(8'h24);
		chk("reload", rv, 32'h02);
		for (int i = 0; i < 2; i++) begin
			wr(8'h28, i ? 8'h07 : 8'h05);
			wr(8'h24, 8'h02);
			pulse(4);
			rd(8'h24);
			chk("single shot", rv, 32'h00);
		end
		$display("modes done");
		wr(8'h2C, 8'h28);
		wr(8'h28, 8'h01);
		wr(8'h24, 8'h05);
		@(posedge aclk) ext <= 1'h1;
		repeat (3) @(posedge aclk);
		rd(8'h24);
		chk("rising edge", rv, 32'h04);
		@(posedge aclk) ext <= 1'h0;
		repeat (3) @(posedge aclk);
		rd(8'h24);
		chk("falling ignored", rv, 32'h04);
		for (int c = 0; c < 6; c++) begin
			wr(8'h2C, 8'h30 | 8'(c));
			wr(8'h24, 8'h10);
			pulse(4 << c);
			rd(8'h24);
			chk("prescaled", rv, 32'h0E);
		end
		rd(8'h34);
		chk("prescale value", rv, 32'hFB);
		$display("prescaler done");
		wr(8'h2C, 8'h08);
		wr(8'h24, 8'h80);
		repeat (10) @(posedge aclk);
		rd(8'h24);
		chk("instruction clock", rv < 32'h80 && rv > 32'h60, 1'h1);
		@(posedge aclk) clk_en <= 1'h0;
		repeat (20) @(posedge aclk);
		clk_en <= 1'h1;
		rd(8'h24);
		chk("clock enable hold", rv, 32'h70);
		@(posedge aclk) wstrb <= 4'h0;
		wr(8'h30, 8'h12);
		chk("masked bresp", r, 32'h0);
		wstrb <= 4'hF;
		rd(8'h30);
		chk("masked write", rv, 32'hFF);
		wr(8'h28, 8'h00);
		@(posedge aclk) gpio_out <= 1'h1;
		gpio_oe <= 1'h1;
		repeat (3) @(posedge aclk);
		chk("gpio pin", pin, 1'h1);
		chk("gpio oe", oe, 1'h1);
		@(posedge aclk) gpio_oe <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("gpio oe off", oe, 1'h0);
		$display("pin done");
		conclude;
	end
endmodule : test_timer2_pwm_prescaler
